// ===== include/cdspa_pkg.sv
// Purpose: Shared constants and types for the divider phase align block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indexes are kept; byte address is four times the index
`default_nettype none
package cdspa_pkg;
  // Register indexes and the bus address width
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] IDX_DIV_CTRL      = 12'h0108;
  localparam logic [11:0] IDX_PHASE_OFS     = 12'h0109;
  localparam logic [11:0] IDX_ALIGN_CTRL    = 12'h010A;
  localparam logic [11:0] IDX_SYSREF_STATUS = 12'h010B;
  localparam logic [11:0] IDX_SYSREF_MODE   = 12'h0120;
  localparam logic [11:0] IDX_SYSREF_PHASE  = 12'h0129;
  // Field positions
  localparam int AUTO_BIT  = 7;
  localparam int NEG_LSB   = 2;
  localparam int POS_LSB   = 0;
  localparam int MODE_LSB  = 1;
  localparam int RATIO_LSB = 0;
  localparam int PHASE_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_DIV_CTRL   = 8'h00;
  localparam logic [7:0] RST_PHASE_OFS  = 8'h00;
  localparam logic [7:0] RST_ALIGN_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE       = 8'h00;
  localparam logic [3:0] RST_PHASE      = 4'h0;
  // Divider ratio codes and half-cycle step per clock
  localparam logic [2:0] RATIO_DIV2 = 3'h1;
  localparam logic [2:0] RATIO_DIV4 = 3'h3;
  localparam logic [3:0] HALF_STEP  = 4'h2;

  typedef logic [3:0] cdspa_phase_t;

  // Live configuration handed to the capture unit
  typedef struct packed {
    logic         auto_en;
    logic [1:0]   neg_win;
    logic [1:0]   pos_win;
    logic         sysref_on;
    cdspa_phase_t period;
  } cdspa_cfg_s;

  // One SYSREF capture result
  typedef struct packed {
    logic         hit;
    logic         ignored;
    cdspa_phase_t phase;
  } cdspa_capture_s;
endpackage
`default_nettype wire

// ===== rtl/cdspa_sysref_capture.sv
// Purpose: Catch SYSREF rising edges and the divider phase at that moment
// Assumes: SYSREF is synchronous to the device clock
// Notes:   Result appears one clock after the edge
`timescale 1ns/1ns
`default_nettype none
module cdspa_sysref_capture (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Event and context
  input  wire logic                     sysref,
  input  wire cdspa_pkg::cdspa_cfg_s    cfg,
  input  wire cdspa_pkg::cdspa_phase_t  div_phase,
  // Result
  output cdspa_pkg::cdspa_capture_s     cap
);
  import cdspa_pkg::*;

  logic           sysref_q;
  logic           next_sysref_q;
  cdspa_capture_s next_cap;
  logic           edge_seen;
  logic           in_window;

  always_comb begin
    next_sysref_q = sysref;
    edge_seen     = sysref && !sysref_q;
    // Near the divider edge the event counts as aligned and is dropped
    in_window = (div_phase != 4'h0) &&
                ((div_phase <= {2'b00, cfg.pos_win}) ||
                 (div_phase >= cfg.period - {2'b00, cfg.neg_win}));
    next_cap.hit     = edge_seen && cfg.sysref_on && cfg.auto_en;
    next_cap.ignored = cfg.auto_en && in_window;
    next_cap.phase   = div_phase;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_q <= 1'b0;
      cap      <= '0;
    end else begin
      sysref_q <= next_sysref_q;
      cap      <= next_cap;
    end
  end

  property p_no_hit_when_off;
    @(posedge clk) disable iff (!rst_n)
      !cfg.auto_en |=> !cap.hit;
  endproperty
  a_no_hit_when_off: assert property (p_no_hit_when_off) else $error("capture while auto adjust off");

  property p_phase_taken;
    @(posedge clk) disable iff (!rst_n)
      (sysref && !sysref_q && cfg.sysref_on && cfg.auto_en) |=> (cap.hit && cap.phase == $past(div_phase));
  endproperty
  a_phase_taken: assert property (p_phase_taken) else $error("sysref phase not captured");

  property p_exact_window;
    @(posedge clk) disable iff (!rst_n)
      (cfg.neg_win == 2'h0 && cfg.pos_win == 2'h0) |=> !cap.ignored;
  endproperty
  a_exact_window: assert property (p_exact_window) else $error("zero windows ignored an event");
endmodule
`default_nettype wire

// ===== rtl/cdspa_top.sv
// Purpose: Input clock divider phase control with SYSREF auto alignment
// Assumes: MCLK is the device input clock; APB master keeps the protocol
// Notes:   Phases count in half input-clock units
`timescale 1ns/1ns
`default_nettype none
module cdspa_top (
  // Clock and reset
  input  wire logic                          MCLK,
  input  wire logic                          RST_N,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [cdspa_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Timing reference
  input  wire logic                          SYSREF,
  // Divider view
  output logic                               DIV_OUT,
  output cdspa_pkg::cdspa_phase_t            DIV_PHASE
);
  import cdspa_pkg::*;

  // Register file
  logic [2:0]     ratio;
  logic [3:0]     phase_ofs;
  logic           auto_en;
  logic [1:0]     neg_win;
  logic [1:0]     pos_win;
  logic [1:0]     sysref_mode;
  cdspa_phase_t   sys_phase;
  logic [2:0]     next_ratio;
  logic [3:0]     next_phase_ofs;
  logic           next_auto_en;
  logic [1:0]     next_neg_win;
  logic [1:0]     next_pos_win;
  logic [1:0]     next_sysref_mode;
  cdspa_phase_t   next_sys_phase;
  // Bus answer
  logic [31:0]    next_prdata;
  logic           next_pready;
  logic           next_pslverr;
  logic           bus_done;
  logic [11:0]    idx;
  logic           addr_ok;
  logic [7:0]     rd_byte;
  // Divider
  cdspa_phase_t   div_cnt;
  cdspa_phase_t   next_div_cnt;
  cdspa_phase_t   eff_ofs;
  cdspa_phase_t   adj_phase;
  cdspa_phase_t   half_period;
  logic           next_div_out;
  cdspa_phase_t   next_div_phase;
  cdspa_cfg_s     cfg;
  cdspa_capture_s cap;

  always_comb begin
    // Word-aligned addresses only; the low two bits are ignored
    idx         = {2'b00, PADDR[ADDR_W-1:2]};
    bus_done    = PSEL && PENABLE && PREADY;
    addr_ok     = 1'b1;
    rd_byte     = 8'h00;
    unique case (idx)
      IDX_DIV_CTRL:      rd_byte = {5'h00, ratio};
      IDX_PHASE_OFS:     rd_byte = {4'h0, phase_ofs};
      IDX_ALIGN_CTRL:    rd_byte = {auto_en, 3'b000, neg_win, pos_win};
      IDX_SYSREF_STATUS: rd_byte = {4'h0, sys_phase};
      IDX_SYSREF_MODE:   rd_byte = {5'h00, sysref_mode, 1'b0};
      IDX_SYSREF_PHASE:  rd_byte = {4'h0, sys_phase};
      default:           addr_ok = 1'b0;
    endcase
    // One wait state: ready rises in the second access cycle
    next_pready  = PSEL && PENABLE && !PREADY;
    next_prdata  = PRDATA;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_prdata  = PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      next_pslverr = !addr_ok;
    end
  end

  always_comb begin
    next_ratio       = ratio;
    next_phase_ofs   = phase_ofs;
    next_auto_en     = auto_en;
    next_neg_win     = neg_win;
    next_pos_win     = pos_win;
    next_sysref_mode = sysref_mode;
    next_sys_phase   = sys_phase;
    if (bus_done && PWRITE) begin
      unique case (idx)
        IDX_DIV_CTRL:    next_ratio = PWDATA[RATIO_LSB +: 3];
        IDX_PHASE_OFS:   next_phase_ofs = PWDATA[PHASE_LSB +: 4];
        IDX_ALIGN_CTRL: begin
          // Bits 6:4 have no storage, so writes there vanish
          next_auto_en = PWDATA[AUTO_BIT];
          next_neg_win = PWDATA[NEG_LSB +: 2];
          next_pos_win = PWDATA[POS_LSB +: 2];
        end
        IDX_SYSREF_MODE: next_sysref_mode = PWDATA[MODE_LSB +: 2];
        default: begin
        end
      endcase
    end
    // Accepted events replace the stored phase; dropped ones leave it
    if (cap.hit && !cap.ignored) begin
      next_sys_phase = cap.phase;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ratio       <= RST_DIV_CTRL[2:0];
      phase_ofs   <= RST_PHASE_OFS[3:0];
      auto_en     <= RST_ALIGN_CTRL[AUTO_BIT];
      neg_win     <= RST_ALIGN_CTRL[NEG_LSB +: 2];
      pos_win     <= RST_ALIGN_CTRL[POS_LSB +: 2];
      sysref_mode <= RST_MODE[MODE_LSB +: 2];
      sys_phase   <= RST_PHASE;
      PRDATA      <= 32'h0000_0000;
      PREADY      <= 1'b0;
      PSLVERR     <= 1'b0;
    end else begin
      ratio       <= next_ratio;
      phase_ofs   <= next_phase_ofs;
      auto_en     <= next_auto_en;
      neg_win     <= next_neg_win;
      pos_win     <= next_pos_win;
      sysref_mode <= next_sysref_mode;
      sys_phase   <= next_sys_phase;
      PRDATA      <= next_prdata;
      PREADY      <= next_pready;
      PSLVERR     <= next_pslverr;
    end
  end

  always_comb begin
    // Period in half units; unlisted ratio codes fall back to divide by 1
    unique case (ratio)
      RATIO_DIV2: half_period = 4'h4;
      RATIO_DIV4: half_period = 4'h8;
      default:    half_period = 4'h2;
    endcase
    cfg.auto_en   = auto_en;
    // Windows are cleared to zero unless auto adjust is on
    cfg.neg_win   = auto_en ? neg_win : 2'b00;
    cfg.pos_win   = auto_en ? pos_win : 2'b00;
    cfg.sysref_on = (sysref_mode != 2'b00);
    cfg.period    = half_period;
    next_div_cnt  = (div_cnt + HALF_STEP) & (half_period - 4'h1);
    eff_ofs       = auto_en ? sys_phase + phase_ofs : phase_ofs;
    // Odd offsets give half-unit steps in DIV_PHASE only; DIV_OUT is registered on MCLK rising edges and moves in whole clocks
    adj_phase     = (div_cnt - eff_ofs) & (half_period - 4'h1);
    next_div_out  = (adj_phase < (half_period >> 1));
    next_div_phase = adj_phase;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt   <= RST_PHASE;
      DIV_OUT   <= 1'b0;
      DIV_PHASE <= RST_PHASE;
    end else begin
      div_cnt   <= next_div_cnt;
      DIV_OUT   <= next_div_out;
      DIV_PHASE <= next_div_phase;
    end
  end

  cdspa_sysref_capture u_capture (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .sysref    (SYSREF),
    .cfg       (cfg),
    .div_phase (div_cnt),
    .cap       (cap)
  );

  property p_offset_delay;
    @(posedge MCLK) disable iff (!RST_N)
      DIV_PHASE == (($past(div_cnt) - $past(eff_ofs)) & ($past(half_period) - 4'h1));
  endproperty
  a_offset_delay: assert property (p_offset_delay) else $error("divider phase not delayed by offset");

  property p_sum_offset;
    @(posedge MCLK) disable iff (!RST_N)
      auto_en |-> eff_ofs == cdspa_phase_t'(sys_phase + phase_ofs);
  endproperty
  a_sum_offset: assert property (p_sum_offset) else $error("effective offset is not the sum");

  property p_off_untouched;
    @(posedge MCLK) disable iff (!RST_N)
      !auto_en |-> eff_ofs == phase_ofs;
  endproperty
  a_off_untouched: assert property (p_off_untouched) else $error("sysref moved phase while off");

  property p_realign;
    @(posedge MCLK) disable iff (!RST_N)
      (cap.hit && !cap.ignored) |=> sys_phase == $past(cap.phase);
  endproperty
  a_realign: assert property (p_realign) else $error("accepted sysref did not realign");

  property p_window_drop;
    @(posedge MCLK) disable iff (!RST_N)
      (cap.hit && cap.ignored) |=> $stable(sys_phase);
  endproperty
  a_window_drop: assert property (p_window_drop) else $error("windowed sysref changed phase");

  property p_window_gate;
    @(posedge MCLK) disable iff (!RST_N)
      !auto_en |-> (cfg.neg_win == 2'b00 && cfg.pos_win == 2'b00);
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("windows live while auto off");

  property p_reserved_zero;
    @(posedge MCLK) disable iff (!RST_N)
      (PSEL && PENABLE && !PWRITE && !PREADY && idx == IDX_ALIGN_CTRL) |=> PRDATA[6:4] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// ===== tb/cdspa_sysref_src.sv
// Purpose: SYSREF source model giving one-clock timing pulses
// Assumes: Line is synchronous to the device clock
// Notes:   Low between pulses, so every request is a fresh rising edge
`timescale 1ns/1ns
`default_nettype none
module cdspa_sysref_src (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Request and line
  input  wire logic fire,
  output var  logic sysref
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sysref <= 1'b0;
    else
      sysref <= fire;
  end
endmodule
`default_nettype wire

// ===== tb/cdspa_top_tb_top.sv
// Purpose: Self-checking bench for the divider phase align block
// Assumes: Divider set to divide by 4, so phases run modulo 8
// Notes:   Counter origin is undefined, so it is synced once
`timescale 1ns/1ns
`default_nettype none
module cdspa_top_tb_top;
  import cdspa_pkg::*;
  logic         mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000, prdata, rd;
  logic         pready, pslverr, sysref, div_out, err;
  cdspa_phase_t div_phase;
  logic [2:0]   tick2 = 3'h0, base = 3'h0, eff = 3'h0, t;
  logic [3:0]   ofs = 4'h0;
  logic [11:0]  regs [6] = '{12'h420, 12'h424, 12'h428, 12'h42C, 12'h480, 12'h4A4};
  logic [3:0]   codes [3] = '{4'h2, 4'hE, 4'hF};
  int           mismatches = 0, check_count = 0;
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) tick2 <= tick2 + 3'h2;
  cdspa_sysref_src SRC (.clk(mclk), .rst_n(rst_n), .fire(fire), .sysref(sysref));
  cdspa_top DUT (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYSREF(sysref), .DIV_OUT(div_out), .DIV_PHASE(div_phase));
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ph(input logic [3:0] exp);
    check_count++;
    if (div_phase !== exp) begin
      mismatches++;
      $display("BAD %0t phase got %h exp %h", $time, div_phase, exp);
    end
  endtask
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic chk_out(input logic exp);
    check_count++;
    if (div_out !== exp) begin
      mismatches++;
      $display("BAD %0t divider out got %b exp %b", $time, div_out, exp);
    end
  endtask
  // Expected phase is counter minus effective offset, modulo the period of 8
  function automatic logic [3:0] exp_phase(input logic [2:0] b, input logic [2:0] tk, input logic [2:0] e);
    return {1'b0, 3'(b + tk - e)};
  endfunction
  task automatic ph_chk();
    logic [3:0] e;
    repeat (4) @(posedge mclk);
    repeat (3) begin
      @(posedge mclk);
      #1;
      e = exp_phase(base, tick2, eff);
      chk_ph(e);
      chk_out(e < 4'h4);
    end
  endtask
  // Pulse lands so the counter reads t at the capturing edge
  task automatic fire_at(input logic [2:0] tg);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (base + tick2 + 3'h6 != tg && n < 8);
    // The counter only takes even phases, so an odd target would never come
    if (base + tick2 + 3'h6 != tg) begin
      mismatches++;
      tally_and_finish();
    end else begin
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
    end
  endtask
  task automatic win_case(input logic [7:0] c, input logic [2:0] tg, input logic [2:0] s);
    apb(1'b1, 12'h480, 32'h0000_0000);
    apb(1'b1, 12'h428, {24'h0, c});
    apb(1'b1, 12'h480, 32'h0000_0002);
    fire_at(tg);
    repeat (3) @(posedge mclk);
    apb(1'b0, 12'h42C, 32'h0000_0000);
    chk_reg(rd, {29'h0, s});
    apb(1'b0, 12'h4A4, 32'h0000_0000);
    chk_reg(rd, {29'h0, s});
    eff = s + ofs[2:0];
    ph_chk();
  endtask
  initial begin
    void'($urandom(32'ha15e));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0000_0000);
      chk_reg(rd, 32'h0000_0000);
    end
    apb(1'b0, 12'h400, 32'h0000_0000);
    chk_reg({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 12'h428, 32'h0000_00FF);
    apb(1'b0, 12'h428, 32'h0000_0000);
    chk_reg(rd, 32'h0000_008F);
    apb(1'b1, 12'h428, 32'h0000_0000);
    apb(1'b1, 12'h420, 32'h0000_0003);
    repeat (4) @(posedge mclk);
    @(posedge mclk);
    #1;
    base = div_phase[2:0] - tick2;
    for (int i = 0; i < 7; i++) begin
      ofs = (i < 3) ? codes[i] : 4'($urandom);
      apb(1'b1, 12'h424, {28'h0, ofs});
      eff = ofs[2:0];
      ph_chk();
    end
    win_case(8'h00, 3'($urandom) & 3'h6, 3'h0);
    win_case(8'h08, 3'h6, 3'h0);
    repeat (3) begin
      t = 3'($urandom) & 3'h6;
      win_case(8'h80, t, t);
    end
    win_case(8'h80, 3'h4, 3'h4);
    win_case(8'h88, 3'h6, 3'h4);
    win_case(8'h88, 3'h2, 3'h2);
    win_case(8'h82, 3'h4, 3'h4);
    win_case(8'h82, 3'h2, 3'h4);
    win_case(8'h81, 3'h2, 3'h2);
    win_case(8'h82, 3'h0, 3'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
